// ===== core/rbit_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "rbit_cfg.svh"
module rbit_addr_gen #(
	parameter int PTR_W = `RBIT_PTR_W
) (
	// operands
	input wire rbit_pkg::addr_mode_e mode,
	input wire logic two_bit,
	input wire logic [PTR_W-1:0] aux_pointer,
	input wire logic [PTR_W-1:0] buffer_start_value,
	input wire logic circular,
	input wire logic [PTR_W-1:0] temp_index_zero,
	input wire logic [PTR_W-1:0] aux_index_zero,
	input wire logic compat_mode_bit,
	// results
	output logic [PTR_W-1:0] bit_address,
	output logic [PTR_W-1:0] next_pointer,
	output logic pointer_write
);
	import rbit_pkg::*;
	// a step of two needs at least two pointer bits
	if (PTR_W < 2) begin : g_bad_width
		$error("rbit_addr_gen: pointer width too small");
	end
	logic [PTR_W-1:0] step;
	logic [PTR_W-1:0] index;
	logic [PTR_W-1:0] base;
	// ------------------------------------------------------------
	// pointer update and address base
	// ------------------------------------------------------------
	always_comb begin
		step = two_bit ? PTR_W'(`RBIT_STEP_TWO) : PTR_W'(`RBIT_STEP_ONE); // [RULE_12]
		index = compat_mode_bit ? aux_index_zero : temp_index_zero; // [RULE_06]
		next_pointer = aux_pointer;
		pointer_write = 1'b0;
		base = aux_pointer;
		case (mode)
			MODE_PLAIN: begin
				pointer_write = 1'b0; // [RULE_01]
			end
			MODE_POST_INC: begin
				next_pointer = aux_pointer + step; // [RULE_02]
				pointer_write = 1'b1;
			end
			MODE_POST_DEC: begin
				next_pointer = aux_pointer - step; // [RULE_03]
				pointer_write = 1'b1;
			end
			MODE_PRE_INC: begin
				next_pointer = aux_pointer + step; // [RULE_04]
				base = next_pointer;
				pointer_write = 1'b1;
			end
			MODE_PRE_DEC: begin
				next_pointer = aux_pointer - step; // [RULE_05]
				base = next_pointer;
				pointer_write = 1'b1;
			end
			MODE_POST_ADD_INDEX: begin
				next_pointer = aux_pointer + index; // [RULE_06]
				pointer_write = 1'b1;
			end
			default: begin
				pointer_write = 1'b0;
			end
		endcase
		// circular pointers add the buffer start; the pointer itself is not wrapped here
		bit_address = circular ? base + buffer_start_value : base; // [RULE_10]
	end
endmodule // rbit_addr_gen
`default_nettype wire

// ===== core/rbit_indirect.sv
`timescale 1ns/1ps
`default_nettype none
`include "rbit_cfg.svh"
// Behaviour
// [RULE_01] plain pointer: address is pointer plus optional buffer start, pointer kept
// [RULE_02] post-increment: address from current pointer, then pointer plus one or two
// [RULE_03] post-decrement: address from current pointer, then pointer minus one or two
// [RULE_04] pre-increment: pointer plus one or two first, address from new pointer
// [RULE_05] pre-decrement: pointer minus one or two first, address from new pointer
// [RULE_06] post-add index: address from pointer, then add index chosen by compat bit
// [RULE_07] pair test reads the addressed bit and the next higher bit
// [RULE_08] pair test copies low bit to flag one, high bit to flag two
// [RULE_09] bit set forces only the addressed bit to one
// [RULE_10] circular pointer adds matching buffer start value to the address
// [RULE_11] only accumulators, auxiliary and temporary registers, only bit operations
// [RULE_12] pair test steps by two; all other operations step by one
module rbit_indirect #(
	parameter int PTR_W = `RBIT_PTR_W,
	parameter int DATA_W = `RBIT_DATA_W,
	parameter int BITNUM_W = `RBIT_BITNUM_W
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// operation request
	input wire logic op_valid,
	input wire rbit_pkg::bit_op_e op,
	input wire rbit_pkg::addr_mode_e mode,
	input wire logic [`RBIT_REG_SEL_W-1:0] reg_sel,
	input wire logic [DATA_W-1:0] src_value,
	// pointer context
	input wire logic [PTR_W-1:0] aux_pointer,
	input wire logic [PTR_W-1:0] buffer_start_value,
	input wire logic circular,
	input wire logic [PTR_W-1:0] temp_index_zero,
	input wire logic [PTR_W-1:0] aux_index_zero,
	input wire logic compat_mode_bit,
	// results
	output logic done,
	output logic illegal,
	output logic [PTR_W-1:0] pointer_out,
	output logic pointer_write,
	output logic [PTR_W-1:0] bit_address,
	output logic [DATA_W-1:0] result_value,
	output logic result_write,
	output logic test_flag_one,
	output logic test_flag_two,
	output logic flags_write
);
	import rbit_pkg::*;

	// refuse widths that the bit indexing cannot serve, at elaboration
	if (PTR_W < BITNUM_W || DATA_W < 2 || DATA_W > (1 << BITNUM_W)) begin : g_bad_width
		$error("rbit_indirect: unsupported width parameters");
	end

	// ------------------------------------------------------------
	// reset synchroniser
	// ------------------------------------------------------------
	logic rst_meta_n;
	logic rst_n;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// ------------------------------------------------------------
	// address generation
	// ------------------------------------------------------------
	logic two_bit;
	logic [PTR_W-1:0] gen_address;
	logic [PTR_W-1:0] gen_pointer;
	logic gen_write;
	logic reg_ok;
	logic [BITNUM_W-1:0] lo_idx;
	logic [BITNUM_W-1:0] hi_idx;
	logic in_range;

	assign two_bit = (op == OP_PAIR_TEST); // [RULE_12]
	// only the sixteen accumulator, auxiliary and temporary registers answer
	assign reg_ok = (reg_sel <= `RBIT_SEL_LAST) && (op <= OP_PAIR_TEST); // [RULE_11]

	rbit_addr_gen #(.PTR_W(PTR_W)) u_gen (
		.mode(mode),
		.two_bit(two_bit),
		.aux_pointer(aux_pointer),
		.buffer_start_value(buffer_start_value),
		.circular(circular),
		.temp_index_zero(temp_index_zero),
		.aux_index_zero(aux_index_zero),
		.compat_mode_bit(compat_mode_bit),
		.bit_address(gen_address),
		.next_pointer(gen_pointer),
		.pointer_write(gen_write)
	);

	function automatic logic [BITNUM_W-1:0] bit_index(input logic [PTR_W-1:0] a);
		bit_index = a[BITNUM_W-1:0];
	endfunction

	assign lo_idx = bit_index(gen_address);
	assign hi_idx = bit_index(gen_address + PTR_W'(1)); // [RULE_07]
	// a bit number past the register width touches nothing
	assign in_range = (gen_address < PTR_W'(DATA_W));

	function automatic logic [DATA_W-1:0] one_hot(input logic [BITNUM_W-1:0] i);
		one_hot = {{(DATA_W-1){1'b0}}, 1'b1} << i;
	endfunction

	// ------------------------------------------------------------
	// handshake and status
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			done <= 1'b0;
			illegal <= 1'b0;
		end else begin
			done <= op_valid;
			illegal <= op_valid && !reg_ok; // [RULE_11]
		end
	end

	// ------------------------------------------------------------
	// pointer write-back
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pointer_out <= '0;
			pointer_write <= 1'b0;
			bit_address <= '0;
		end else begin
			pointer_write <= op_valid && reg_ok && gen_write; // [RULE_01]
			if (op_valid) begin
				pointer_out <= gen_pointer; // [RULE_02]
				bit_address <= gen_address;
			end
		end
	end

	// ------------------------------------------------------------
	// bit operation on the source register
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			result_value <= '0;
			result_write <= 1'b0;
		end else begin
			result_write <= 1'b0;
			if (op_valid && reg_ok) begin
				result_value <= src_value;
				case (op)
					OP_SET: begin
						if (in_range)
							result_value <= src_value | one_hot(lo_idx); // [RULE_09]
						result_write <= 1'b1;
					end
					OP_CLEAR: begin
						if (in_range)
							result_value <= src_value & ~one_hot(lo_idx);
						result_write <= 1'b1;
					end
					OP_COMPLEMENT: begin
						if (in_range)
							result_value <= src_value ^ one_hot(lo_idx);
						result_write <= 1'b1;
					end
					default: begin
						result_write <= 1'b0;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// test flags
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			test_flag_one <= 1'b0;
			test_flag_two <= 1'b0;
			flags_write <= 1'b0;
		end else begin
			flags_write <= op_valid && reg_ok && (op == OP_TEST || op == OP_PAIR_TEST);
			if (op_valid && reg_ok && op == OP_TEST) begin
				test_flag_one <= in_range && src_value[lo_idx];
			end else if (op_valid && reg_ok && op == OP_PAIR_TEST) begin
				test_flag_one <= in_range && src_value[lo_idx]; // [RULE_08]
				// compared without the +1 so an all-ones address cannot wrap to bit zero
				test_flag_two <= (gen_address < PTR_W'(DATA_W - 1))
					&& src_value[hi_idx]; // [RULE_07]
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_plain_keeps_ptr: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_01]
		op_valid && mode == MODE_PLAIN |=> !pointer_write)
		else $error("plain pointer was written");
	a_post_inc_step: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_02]
		op_valid && reg_ok && mode == MODE_POST_INC |=>
		pointer_write && pointer_out == PTR_W'($past(aux_pointer) + ($past(two_bit) ? 2 : 1)))
		else $error("post increment wrong");
	a_post_dec_step: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_03]
		op_valid && reg_ok && mode == MODE_POST_DEC |=>
		pointer_out == PTR_W'($past(aux_pointer) - ($past(two_bit) ? 2 : 1)))
		else $error("post decrement wrong");
	a_pre_inc_addr: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_04]
		op_valid && !circular && mode == MODE_PRE_INC |=> bit_address == pointer_out)
		else $error("pre increment address not from new pointer");
	a_pre_dec_addr: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_05]
		op_valid && !circular && mode == MODE_PRE_DEC |=> bit_address == pointer_out)
		else $error("pre decrement address not from new pointer");
	a_index_select: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_06]
		op_valid && mode == MODE_POST_ADD_INDEX |=> pointer_out == PTR_W'($past(aux_pointer)
		+ ($past(compat_mode_bit) ? $past(aux_index_zero) : $past(temp_index_zero))))
		else $error("index add wrong");
	a_pair_flags: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_08]
		op_valid && reg_ok && op == OP_PAIR_TEST && gen_address < 16'h0020 |=>
		test_flag_one == $past(src_value[lo_idx]) && test_flag_two == $past(src_value[hi_idx]))
		else $error("pair test flags wrong");
	a_set_one_bit: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_09]
		op_valid && reg_ok && op == OP_SET |=>
		$countones(result_value ^ $past(src_value)) <= 1
		&& (result_value | $past(src_value)) == result_value
		&& (!$past(in_range) || result_value[$past(lo_idx)]))
		else $error("bit set touched other bits");
	a_circ_offset: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_10]
		op_valid && circular && mode == MODE_PLAIN |=>
		bit_address == PTR_W'($past(aux_pointer) + $past(buffer_start_value)))
		else $error("circular offset missing");
	a_bad_reg: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_11]
		op_valid && !reg_ok |=> illegal && !result_write && !pointer_write && !flags_write)
		else $error("illegal register accessed");
	a_step_size: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_12]
		op_valid && reg_ok && op == OP_SET && mode == MODE_POST_INC |=>
		pointer_out == PTR_W'($past(aux_pointer) + 1))
		else $error("single bit step not one");
	c_pair_test: cover property (@(posedge mclk) op_valid && op == OP_PAIR_TEST);
	c_pre_dec: cover property (@(posedge mclk) op_valid && mode == MODE_PRE_DEC);
	c_circular: cover property (@(posedge mclk) op_valid && circular);
	c_compat: cover property (@(posedge mclk) op_valid && compat_mode_bit
		&& mode == MODE_POST_ADD_INDEX);
endmodule // rbit_indirect
`default_nettype wire

// ===== include/rbit_cfg.svh
`ifndef RBIT_CFG_SVH
`define RBIT_CFG_SVH
// pointer and data widths
`define RBIT_PTR_W 16
`define RBIT_DATA_W 40
`define RBIT_BITNUM_W 6
// register file selection
`define RBIT_NUM_AC 4
`define RBIT_NUM_AR 8
`define RBIT_NUM_T 4
`define RBIT_REG_SEL_W 5
`define RBIT_SEL_AC_BASE 5'h00
`define RBIT_SEL_AR_BASE 5'h04
`define RBIT_SEL_T_BASE 5'h0c
`define RBIT_SEL_LAST 5'h0f
// pointer step sizes
`define RBIT_STEP_ONE 16'h0001
`define RBIT_STEP_TWO 16'h0002
`endif

// ===== include/rbit_pkg.sv
package rbit_pkg;
	typedef enum logic [2:0] {
		MODE_PLAIN,
		MODE_POST_INC,
		MODE_POST_DEC,
		MODE_PRE_INC,
		MODE_PRE_DEC,
		MODE_POST_ADD_INDEX
	} addr_mode_e;
	typedef enum logic [2:0] {
		OP_TEST,
		OP_SET,
		OP_CLEAR,
		OP_COMPLEMENT,
		OP_PAIR_TEST
	} bit_op_e;
	typedef enum {
		ST_IDLE,
		ST_DONE
	} op_state_e;
endpackage

// ===== test/register_bit_indirect_addressing_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rbit_cfg.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
	$display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module register_bit_indirect_addressing_tb;
import rbit_pkg::*;
// ----------------------------------------
// stimulus and observed signals
// ----------------------------------------
logic mclk, resetn, op_valid, circular, compat_mode_bit;
bit_op_e op;
addr_mode_e mode;
logic [`RBIT_REG_SEL_W-1:0] reg_sel;
logic [`RBIT_DATA_W-1:0] src_value, result_value;
logic [`RBIT_PTR_W-1:0] aux_pointer, buffer_start_value, temp_index_zero, aux_index_zero;
logic [`RBIT_PTR_W-1:0] pointer_out, bit_address;
logic done, illegal, pointer_write, result_write, test_flag_one, test_flag_two, flags_write;
int errors, n_compared;
logic [31:0] lfsr = 32'hc6bdf158;
logic [31:0] r;
logic [63:0] r64;
logic exp_f1, exp_f2;

rbit_indirect rbit_indirect_i (.mclk(mclk), .resetn(resetn), .op_valid(op_valid), .op(op),
	.mode(mode), .reg_sel(reg_sel), .src_value(src_value), .aux_pointer(aux_pointer),
	.buffer_start_value(buffer_start_value), .circular(circular),
	.temp_index_zero(temp_index_zero), .aux_index_zero(aux_index_zero),
	.compat_mode_bit(compat_mode_bit), .done(done), .illegal(illegal),
	.pointer_out(pointer_out), .pointer_write(pointer_write), .bit_address(bit_address),
	.result_value(result_value), .result_write(result_write), .test_flag_one(test_flag_one),
	.test_flag_two(test_flag_two), .flags_write(flags_write));

initial begin
	mclk = 1'b0;
	forever #50 mclk = ~mclk;
end

// ----------------------------------------
// reference helpers
// ----------------------------------------
function automatic logic [31:0] rnd();
	lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
	return lfsr;
endfunction

// bits past the register width do not exist and read as zero
function automatic logic bit_of(logic [`RBIT_DATA_W-1:0] v, int n);
	return (n < `RBIT_DATA_W) ? v[n] : 1'b0;
endfunction

task automatic end_of_test();
	$display("compared %0d mismatches %0d", n_compared, errors);
	if (errors == 0 && n_compared > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask

// drives one request at edge+1, checks the answer one edge later; op_valid is left high
// so consecutive calls run back to back
task automatic run_op(bit_op_e o, addr_mode_e m, logic [4:0] rs, logic [39:0] src,
	logic [15:0] ptr, logic [15:0] bsa, logic circ, logic cm, logic [15:0] t0, logic [15:0] a0);
	logic [15:0] step, newp, addr;
	logic [39:0] res;
	logic two, bad, wr_res, wr_flg;
	int bn;
	op_valid = 1'b1;
	op = o;
	mode = m;
	reg_sel = rs;
	src_value = src;
	aux_pointer = ptr;
	buffer_start_value = bsa;
	circular = circ;
	compat_mode_bit = cm;
	temp_index_zero = t0;
	aux_index_zero = a0;
	two = (o == OP_PAIR_TEST);
	step = two ? `RBIT_STEP_TWO : `RBIT_STEP_ONE;
	case (m)
		MODE_POST_INC, MODE_PRE_INC: newp = ptr + step;
		MODE_POST_DEC, MODE_PRE_DEC: newp = ptr - step;
		MODE_POST_ADD_INDEX: newp = ptr + (cm ? a0 : t0);
		default: newp = ptr;
	endcase
	addr = ((m == MODE_PRE_INC || m == MODE_PRE_DEC) ? newp : ptr) + (circ ? bsa : 16'h0000);
	// the whole address picks the bit; anything past the register touches nothing
	bn = int'(addr);
	res = src;
	if (bn < `RBIT_DATA_W && o == OP_SET) res[bn] = 1'b1;
	if (bn < `RBIT_DATA_W && o == OP_CLEAR) res[bn] = 1'b0;
	if (bn < `RBIT_DATA_W && o == OP_COMPLEMENT) res[bn] = ~src[bn];
	bad = (rs > 5'h0f);
	wr_res = !bad && (o == OP_SET || o == OP_CLEAR || o == OP_COMPLEMENT);
	wr_flg = !bad && (o == OP_TEST || two);
	if (wr_flg) exp_f1 = bit_of(src, bn);
	if (wr_flg && two) exp_f2 = bit_of(src, bn + 1);
	@(posedge mclk);
	#1;
	`CHK(done, 1'b1)
	`CHK(illegal, bad)
	`CHK(pointer_write, !bad && m != MODE_PLAIN)
	`CHK(result_write, wr_res)
	`CHK(flags_write, wr_flg)
	if (!bad) `CHK(bit_address, addr)
	if (!bad && m != MODE_PLAIN) `CHK(pointer_out, newp)
	if (!bad && m == MODE_POST_ADD_INDEX) `CHK(pointer_out, newp)
	if (wr_res) `CHK(result_value, res)
	`CHK(test_flag_one, exp_f1)
	`CHK(test_flag_two, exp_f2)
endtask

task automatic go_idle();
	op_valid = 1'b0;
	@(posedge mclk);
	#1;
	`CHK({done, illegal, pointer_write, result_write, flags_write}, 5'h00)
endtask

// ----------------------------------------
// main sequence
// ----------------------------------------
initial begin
	{resetn, op_valid, circular, compat_mode_bit, reg_sel} = 9'h000;
	{src_value, aux_pointer, buffer_start_value, temp_index_zero, aux_index_zero} = '0;
	op = OP_TEST;
	mode = MODE_PLAIN;
	{exp_f1, exp_f2} = 2'b00;
	repeat (12) @(posedge mclk);
	#1;
	resetn = 1'b1;
	repeat (2) @(posedge mclk);
	#1;
	// outputs stay quiet while the internal reset copy releases
	go_idle();
	run_op(OP_SET, MODE_POST_INC, 5'h03, 40'h0, 16'h0000, 16'h0, 1'b0, 1'b0, 16'h0, 16'h0);
	run_op(OP_PAIR_TEST, MODE_PLAIN, 5'h03, 40'h0040000000,
		16'h001e, 16'h0, 1'b0, 1'b0, 16'h0, 16'h0);
	run_op(OP_PAIR_TEST, MODE_PRE_INC, 5'h03, 40'h0080000000,
		16'h001c, 16'h0, 1'b0, 1'b0, 16'h0, 16'h0);
	run_op(OP_PAIR_TEST, MODE_PRE_DEC, 5'h03, 40'h00c0000000,
		16'h0020, 16'h0, 1'b0, 1'b0, 16'h0, 16'h0);
	run_op(OP_PAIR_TEST, MODE_POST_DEC, 5'h03, 40'h0,
		16'h001e, 16'h0, 1'b0, 1'b0, 16'h0, 16'h0);
	run_op(OP_SET, MODE_POST_ADD_INDEX, 5'h00, 40'h0,
		16'h0002, 16'h0, 1'b0, 1'b0, 16'h000f, 16'h0003);
	run_op(OP_SET, MODE_POST_ADD_INDEX, 5'h00, 40'h0,
		16'h0002, 16'h0, 1'b0, 1'b1, 16'h000f, 16'h0003);
	run_op(OP_SET, MODE_PLAIN, 5'h0c, 40'h0, 16'h0003, 16'h0004, 1'b1, 1'b0, 16'h0, 16'h0);
	run_op(OP_SET, MODE_POST_INC, 5'h10, 40'h0, 16'h0005, 16'h0, 1'b0, 1'b0, 16'h0, 16'h0);
	// bit number 45 does not exist: nothing changes but the pointer still steps
	run_op(OP_CLEAR, MODE_POST_INC, 5'h01, 40'hffffffffff,
		16'h002d, 16'h0, 1'b0, 1'b0, 16'h0, 16'h0);
	go_idle();
	// mid-run reset clears every held output at once
	resetn = 1'b0;
	#1;
	`CHK({pointer_out, bit_address, result_value, test_flag_one, test_flag_two}, '0)
	{exp_f1, exp_f2} = 2'b00;
	@(posedge mclk);
	#1;
	resetn = 1'b1;
	repeat (2) @(posedge mclk);
	#1;
	go_idle();
	$display("test corner done");
	// every op and mode pairing, random operands kept inside the 40-bit range
	for (int k = 0; k < 300; k++) begin
		r = rnd();
		r64 = {rnd(), rnd()};
		run_op(bit_op_e'(k % 5), addr_mode_e'((k / 5) % 6), {1'b0, r[3:0]}, r64[39:0],
			16'h0002 + 16'(r[15:8] % 26), {13'h0, r[18:16]}, r[4], r[5],
			{12'h0, r[31:28]}, {12'h0, r[27:24]});
	end
	go_idle();
	$display("test random done");
	end_of_test();
end

initial begin
	repeat (20000) @(posedge mclk);
	errors++;
	$display("[ERR] %0t run did not finish in time", $time);
	end_of_test();
end
endmodule // register_bit_indirect_addressing_tb
`default_nettype wire
